// ---- rtl/cso_regs.svh ----
/*
 * Constants for the conversion start and over-temperature flag block.
 * Assumes a 50 MHz system clock; all times are turned into cycle counts.
 */
// Overview of operation
// - a temperature result above the 8-bit setpoint raises the flag.
// - the flag drops once a host serial read transaction completes.
// - a rising edge on convert-start powers up the part for 4 us.
// - a pulse longer than power-up enters hold on its falling edge.
// - a shorter pulse holds off hold and conversion until power-up ends.
// - the track-and-hold returns to track when a conversion finishes.
// - channel code 4 selects the external analog input for conversion.
// - results appear 15 us after start for analog, 30 us for temperature.
// - in auto mode a serial transfer starts a conversion 3 us later if the sequencer is then idle.
`ifndef CSO_REGS_SVH
`define CSO_REGS_SVH
`define CSO_CLK_MHZ 50
`define CSO_PWRUP_US 4
`define CSO_CONV_AIN_US 15
`define CSO_CONV_TEMP_US 30
`define CSO_AUTO_DLY_US 3
`define CSO_PWRUP_CYC (`CSO_PWRUP_US * `CSO_CLK_MHZ)
`define CSO_CONV_AIN_CYC (`CSO_CONV_AIN_US * `CSO_CLK_MHZ)
`define CSO_CONV_TEMP_CYC (`CSO_CONV_TEMP_US * `CSO_CLK_MHZ)
`define CSO_AUTO_DLY_CYC (`CSO_AUTO_DLY_US * `CSO_CLK_MHZ)
`define CSO_CH_TEMP 3'h0
`define CSO_CH_AIN 3'h4
`define CSO_SETPOINT_RST 8'h00
`define CSO_CNT_W 11
`endif

// ---- rtl/cso_pkg.sv ----
/*
 * Types for the conversion control block.
 * Assumes cso_regs.svh supplies the numeric constants.
 */
package cso_pkg;
    typedef enum logic [1:0] {CSO_IDLE, CSO_PWRUP, CSO_WAIT_FALL,
        CSO_CONVERT} cso_state_t;
    typedef logic [2:0] cso_chan_t;
endpackage : cso_pkg

// ---- rtl/cso_sync_if.sv ----
/*
 * Interface carrying synchronised pin levels and the transfer-done pulse to the control core.
 * Assumes both ends run on clk.
 */
`timescale 1ns/100ps
interface cso_sync_if;
    logic conv_lvl;
    logic xfer_done;
    logic xfer_read;
    modport src (output conv_lvl, output xfer_done, output xfer_read);
    modport dst (input conv_lvl, input xfer_done, input xfer_read);
endinterface : cso_sync_if

// ---- rtl/cso_sync.sv ----
/*
 * Two-flop synchronisers for pins from outside the clock domain.
 * Assumes asynchronous pins; transfer-done arrives as a level toggle
 * from the serial engine's domain.
 */
`timescale 1ns/100ps
module cso_sync (
    input wire logic clk,          // system clock
    input wire logic sys_rst,      // sync reset, high
    input wire logic conv_pin,     // convert-start pin
    input wire logic xfer_tgl,     // toggles per finished transfer
    input wire logic xfer_rd_pin,  // level: last transfer was a read
    cso_sync_if.src so             // synchronised outputs
);
    logic [1:0] conv_s;
    logic [1:0] tgl_s;
    logic [1:0] rd_s;
    logic tgl_d;

    // ********************************
    // synchronisers; first stage read only by second
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_s <= 2'h0;
            tgl_s <= 2'h0;
            rd_s <= 2'h0;
            tgl_d <= 1'b0;
        end else begin
            conv_s <= {conv_s[0], conv_pin};
            tgl_s <= {tgl_s[0], xfer_tgl};
            rd_s <= {rd_s[0], xfer_rd_pin};
            tgl_d <= tgl_s[1];
        end
    end

    assign so.conv_lvl = conv_s[1];
    assign so.xfer_done = tgl_s[1] ^ tgl_d; // toggle to pulse
    assign so.xfer_read = rd_s[1];
endmodule : cso_sync

// ---- rtl/cso_top.sv ----
/*
 * Conversion start sequencing and over-temperature flag.
 * Assumes the serial engine supplies setpoint, channel, mode and a
 * transfer-done toggle; the converter core consumes hold/start and
 * returns a result when told the conversion time has elapsed.
 */
`timescale 1ns/100ps
`include "cso_regs.svh"
module cso_top (
    input wire logic clk,                 // 50 MHz clock
    input wire logic sys_rst,             // sync reset, high
    input wire logic convert_start_in,    // convert-start pin
    input wire logic xfer_tgl,            // serial transfer done toggle
    input wire logic xfer_rd_pin,         // last transfer was a read
    input wire logic auto_mode,           // automatic conversion mode
    input wire cso_pkg::cso_chan_t chan_sel, // channel select field
    input wire logic [7:0] overtemp_setpoint, // temperature setpoint
    input wire logic [9:0] adc_result,    // result from converter core
    output logic powered_up,              // part at full power
    output logic hold_out,                // high: track-and-hold in hold
    output logic conv_busy,               // conversion in progress
    output logic result_valid,            // one-cycle result strobe
    output logic [9:0] result_data,       // latched result
    output logic [2:0] result_chan,       // channel of latched result
    output logic overtemp_flag_out,       // open-drain drive, high=pull
    output logic overtemp_oe_n            // low while pin driven low
);
    import cso_pkg::*;

    cso_sync_if sif ();
    cso_state_t state_r;
    logic [`CSO_CNT_W-1:0] cnt_r;
    logic [`CSO_CNT_W-1:0] auto_cnt_r;
    logic auto_pend_r;
    logic conv_d_r;
    logic pwr_done_r;
    logic fell_r;
    logic flag_r;
    cso_chan_t chan_r;
    logic rise;
    logic fall;
    logic auto_go;
    logic conv_end;

    cso_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .conv_pin(convert_start_in),
        .xfer_tgl(xfer_tgl),
        .xfer_rd_pin(xfer_rd_pin),
        .so(sif.src)
    );

    // conversion length depends on channel
    function automatic logic [`CSO_CNT_W-1:0] conv_len(input cso_chan_t c);
        if (c == `CSO_CH_TEMP) begin
            conv_len = `CSO_CNT_W'(`CSO_CONV_TEMP_CYC - 1);
        end else begin
            conv_len = `CSO_CNT_W'(`CSO_CONV_AIN_CYC - 1);
        end
    endfunction : conv_len

    // ********************************
    // edge detection on synchronised pin
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conv_d_r <= 1'b0;
        end else begin
            conv_d_r <= sif.conv_lvl;
        end
    end
    assign rise = sif.conv_lvl & ~conv_d_r;
    assign fall = ~sif.conv_lvl & conv_d_r;
    assign conv_end = (state_r == CSO_CONVERT) && (cnt_r == '0);

    // ********************************
    // automatic-mode delay after each transfer
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            auto_pend_r <= 1'b0;
            auto_cnt_r <= '0;
        end else if (auto_mode && sif.xfer_done) begin
            // oscillator restarts at end of transfer
            auto_pend_r <= 1'b1;
            auto_cnt_r <= `CSO_CNT_W'(`CSO_AUTO_DLY_CYC - 1);
        end else if (auto_pend_r) begin
            if (auto_cnt_r == '0) begin
                auto_pend_r <= (state_r == CSO_CONVERT); // wait if busy
            end else begin
                auto_cnt_r <= auto_cnt_r - 1'b1;
            end
        end
    end
    assign auto_go = auto_pend_r && (auto_cnt_r == '0) &&
        (state_r != CSO_CONVERT);

    // ********************************
    // power-up and conversion sequencer
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= CSO_IDLE;
            cnt_r <= '0;
            fell_r <= 1'b0;
            chan_r <= `CSO_CH_TEMP;
        end else begin
            case (state_r)
                CSO_IDLE: begin
                    if (rise) begin
                        state_r <= CSO_PWRUP;
                        cnt_r <= `CSO_CNT_W'(`CSO_PWRUP_CYC - 1);
                        fell_r <= 1'b0;
                    end else if (auto_go) begin
                        state_r <= CSO_CONVERT;
                        chan_r <= chan_sel;
                        cnt_r <= conv_len(chan_sel);
                    end
                end
                CSO_PWRUP: begin
                    if (fall) begin
                        fell_r <= 1'b1;
                    end
                    if (cnt_r == '0) begin
                        if (fell_r || fall) begin
                            // short pulse: start once power-up done
                            state_r <= CSO_CONVERT;
                            chan_r <= chan_sel;
                            cnt_r <= conv_len(chan_sel);
                        end else begin
                            state_r <= CSO_WAIT_FALL;
                        end
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                CSO_WAIT_FALL: begin
                    if (fall) begin
                        state_r <= CSO_CONVERT;
                        chan_r <= chan_sel;
                        cnt_r <= conv_len(chan_sel);
                    end
                end
                CSO_CONVERT: begin
                    if (cnt_r == '0) begin
                        state_r <= CSO_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= CSO_IDLE;
                end
            endcase
        end
    end

    // ********************************
    // registered status outputs
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powered_up <= 1'b0;
            hold_out <= 1'b0;
            conv_busy <= 1'b0;
        end else begin
            powered_up <= (state_r == CSO_WAIT_FALL) ||
                (state_r == CSO_CONVERT);
            hold_out <= (state_r == CSO_CONVERT) && !conv_end;
            conv_busy <= (state_r == CSO_CONVERT) && !conv_end;
        end
    end

    // ********************************
    // result capture
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_valid <= 1'b0;
            result_data <= 10'h000;
            result_chan <= 3'h0;
        end else begin
            result_valid <= conv_end;
            if (conv_end) begin
                result_data <= adc_result;
                result_chan <= chan_r;
            end
        end
    end

    // ********************************
    // over-temperature flag; a set in the clearing cycle wins
    // ********************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_r <= 1'b0;
        end else if (conv_end && chan_r == `CSO_CH_TEMP &&
                adc_result[9:2] > overtemp_setpoint) begin
            flag_r <= 1'b1;
        end else if (sif.xfer_done && sif.xfer_read) begin
            flag_r <= 1'b0;
        end
    end

    // open drain: pin pulled low (oe_n low) when flag active
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overtemp_flag_out <= 1'b0;
            overtemp_oe_n <= 1'b1;
        end else begin
            overtemp_flag_out <= flag_r;
            overtemp_oe_n <= ~flag_r;
        end
    end

    // ********************************
    // checks
    // ********************************
    AST_PWRUP_LEN: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == CSO_IDLE && rise) |=>
        (state_r == CSO_PWRUP) [*8])
        else $error("power-up ended early");
    AST_LONG_FALL: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == CSO_WAIT_FALL && fall) |=> state_r == CSO_CONVERT)
        else $error("no conversion after long pulse fell");
    AST_SHORT_HOLD: assert property (@(posedge clk)
        disable iff (sys_rst)
        (state_r == CSO_PWRUP && cnt_r != '0) |=> !hold_out)
        else $error("hold entered before power-up done");
    AST_TRACK_END: assert property (@(posedge clk) disable iff (sys_rst)
        conv_end |=> !hold_out && result_valid)
        else $error("track not restored at end");
    AST_CHAN: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r != CSO_CONVERT) ##1 (state_r == CSO_CONVERT) |->
        chan_r == $past(chan_sel))
        else $error("wrong channel latched");
    AST_CONV_LEN: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r != CSO_CONVERT) ##1 (state_r == CSO_CONVERT &&
        chan_r == `CSO_CH_AIN) |->
        cnt_r == `CSO_CNT_W'(`CSO_CONV_AIN_CYC - 1))
        else $error("analog conversion length wrong");
    AST_OT_SET: assert property (@(posedge clk) disable iff (sys_rst)
        (conv_end && chan_r == `CSO_CH_TEMP &&
        adc_result[9:2] > overtemp_setpoint) |=> ##1 !overtemp_oe_n)
        else $error("overtemp not raised");
    AST_OT_CLR: assert property (@(posedge clk) disable iff (sys_rst)
        (sif.xfer_done && sif.xfer_read && !conv_end) |=> !flag_r)
        else $error("overtemp not cleared by read");
    AST_AUTO: assert property (@(posedge clk) disable iff (sys_rst)
        (auto_mode && sif.xfer_done && state_r == CSO_IDLE &&
        !sif.conv_lvl) |=> !hold_out [*8])
        else $error("auto conversion too early");
endmodule : cso_top

// ---- verification/cso_host_model.sv ----
/*
 * Host model: ends serial transfers toward the conversion block.
 * Assumes clk is the block's 50 MHz clock, used to align the toggle.
 */
`timescale 1ns/100ps
module cso_host_model (
    input wire logic clk,     // block clock, aligns the toggle
    output logic xfer_tgl,    // toggles once per finished transfer
    output logic xfer_rd_pin  // kind of transfer, high = read
);
    logic scl_r; // link clock, stands still between frames

    // idle bus at time zero
    initial begin
        xfer_tgl = 1'b0;
        xfer_rd_pin = 1'b0;
        scl_r = 1'b1;
    end

    // ************
    // frame
    // ************
    // kind is set before the toggle so the block never sees a stale kind
    task automatic xfer(input logic rd);
        xfer_rd_pin = rd;
        #7;
        repeat (9) begin
            #80 scl_r = 1'b0;
            #80 scl_r = 1'b1;
        end
        @(negedge clk);
        xfer_tgl = ~xfer_tgl;
    endtask : xfer
endmodule : cso_host_model

// ---- verification/cso_top_tb.sv ----
/*
 * Self-checking bench for the conversion start and flag block.
 * Assumes the host model file is compiled first.
 */
`timescale 1ns/100ps
`include "cso_regs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    bad_count++; $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module cso_top_tb;
    import cso_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic convert_start_in = 1'b0;
    logic auto_mode = 1'b0;
    cso_chan_t chan_sel = 3'h0;
    logic [7:0] overtemp_setpoint = 8'h40;
    logic [9:0] adc_result = 10'h000;
    logic xfer_tgl, xfer_rd_pin, powered_up, hold_out, conv_busy;
    logic result_valid, overtemp_flag_out, overtemp_oe_n;
    logic [9:0] result_data;
    logic [2:0] result_chan;
    logic [13:0] expq[$]; // notes: {flag, chan, data}
    logic [13:0] e_m;
    logic flag_m = 1'b0; // expected flag level
    int bad_count = 0;
    int samples_checked = 0;
    int seed = 95;

    always #10 clk = ~clk;

    cso_top cso_top_inst (.clk, .sys_rst, .convert_start_in, .xfer_tgl,
        .xfer_rd_pin, .auto_mode, .chan_sel, .overtemp_setpoint,
        .adc_result, .powered_up, .hold_out, .conv_busy, .result_valid,
        .result_data, .result_chan, .overtemp_flag_out, .overtemp_oe_n);
    cso_host_model cso_host_model_inst (.clk, .xfer_tgl, .xfer_rd_pin);

    // ************
    // result monitor
    // ************
    // flag is looked at a few cycles late: a set may land one edge after
    always @(negedge clk) begin
        if (result_valid === 1'b1) begin
            `CHK("result expected", 1'b1, expq.size() > 0)
            e_m = expq.pop_front();
            `CHK("result_data", e_m[9:0], result_data)
            `CHK("result_chan", e_m[12:10], result_chan)
            `CHK("hold_out", 1'b0, hold_out)
            `CHK("conv_busy", 1'b0, conv_busy)
            repeat (3) @(negedge clk);
            `CHK("overtemp_flag_out", e_m[13], overtemp_flag_out)
            `CHK("overtemp_oe_n", ~e_m[13], overtemp_oe_n)
        end
    end

    // one pulse-started conversion; a second pulse mid-way must be ignored
    task automatic conv(input cso_chan_t c, input int w,
        input logic [9:0] v);
        int n;
        int m;
        n = 0;
        m = 0;
        chan_sel = c;
        adc_result = v;
        if (c == 3'h0 && v[9:2] > overtemp_setpoint) flag_m = 1'b1;
        expq.push_back({flag_m, c, v});
        convert_start_in = 1'b1;
        while (hold_out !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
            if (n == w) convert_start_in = 1'b0;
        end
        convert_start_in = 1'b0;
        if (w > 200) `CHK("hold delay", 1'b1, n > w && n <= w + 8)
        else `CHK("hold delay", 1'b1, n >= 200 && n <= 210)
        `CHK("powered_up", 1'b1, powered_up)
        `CHK("conv_busy", 1'b1, conv_busy)
        while (hold_out === 1'b1 && m < 2000) begin
            @(negedge clk);
            m++;
            convert_start_in = (m >= 10 && m < 30);
        end
        n = (c == 3'h0) ? `CSO_CONV_TEMP_CYC : `CSO_CONV_AIN_CYC;
        `CHK("hold length", 1'b1, m >= n - 1 && m <= n + 1)
        repeat (25) @(negedge clk);
    endtask : conv

    // transfer through the host model, then the flag level is checked
    task automatic host_xfer(input logic rd);
        cso_host_model_inst.xfer(rd);
        if (rd) flag_m = 1'b0;
        repeat (8) @(negedge clk);
        `CHK("flag after transfer", flag_m, overtemp_flag_out)
    endtask : host_xfer

    // automatic mode: the transfer itself starts the conversion
    task automatic auto_conv(input logic rd);
        int n;
        chan_sel = 3'h4;
        adc_result = 10'($random(seed));
        if (rd) flag_m = 1'b0;
        expq.push_back({flag_m, 3'h4, adc_result});
        host_xfer(rd);
        n = 8;
        while (hold_out !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        `CHK("auto delay", 1'b1, n >= 150 && n <= 160)
        `CHK("conv_busy", 1'b1, conv_busy)
        while (hold_out === 1'b1) @(negedge clk);
        repeat (25) @(negedge clk);
    endtask : auto_conv

    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report

    // ************
    // main sequence
    // ************
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        conv(3'h0, 50, {8'h41, 2'b00});
        host_xfer(1'b0);
        host_xfer(1'b1);
        conv(3'h0, 300, {8'h40, 2'b11});
        conv(3'h4, 260, 10'h3FF);
        for (int i = 0; i < 6; i++) begin
            overtemp_setpoint = 8'($random(seed));
            conv(($random(seed) & 1) ? 3'h4 : 3'h0,
                ($random(seed) & 1) ? 20 + i * 20 : 250 + i * 25,
                10'($random(seed)));
            host_xfer(1'($random(seed)));
        end
        auto_mode = 1'b1;
        auto_conv(1'b0);
        auto_conv(1'b1);
        final_report;
    end

    // hang guard, well beyond the length of the sequence above
    initial begin
        #(20 * 80000);
        bad_count++;
        final_report;
    end
endmodule : cso_top_tb
